//--- bench/fault_status_trap_control_bench.sv
/*
  Self-checking bench for the fault status and trap control block.
  Assumes the block's package and constants header are compiled first.
*/
`timescale 1ns/1ps
`include "fault_trap_consts.svh"
module fault_status_trap_control_bench;
  import fault_trap_pkg::*;
  logic i_clk_sys, i_arst_n, i_reset_into_hyp, i_fault_valid, i_fault_sync;
  logic i_fault_addr_unknown, i_fault_cache_maint, i_fault_ext_class, i_fault_write;
  logic i_fault_sys_space, i_sr_valid, i_sr_write, i_memctl_write_trap, i_memctl_read_trap;
  logic i_group5_trap, i_group1_trap, i_acc_ctl_access, i_trace_access;
  logic i_trace_user_forbidden, i_vector_exec, i_fp_access, i_kernel_trapped;
  logic o_rvalid, o_trap_hyp, o_trace_side_effect_en;
  logic [5:0] i_fault_code;
  logic [3:0] i_sr_coproc;
  logic [13:0] i_sr_enc;
  logic [2:0] i_level, o_exc;
  logic [31:0] i_sr_wdata, o_rdata, o_fault_status, o_feature_trap, seed, wd, fs;
  logic [5:0] codes [10];
  int n_mismatch, n_checks;
  fault_status_trap_control dut_u (.i_clk_sys, .i_arst_n, .i_reset_into_hyp, .i_fault_valid,
    .i_fault_code, .i_fault_sync, .i_fault_addr_unknown, .i_fault_cache_maint,
    .i_fault_ext_class, .i_fault_write, .i_fault_sys_space, .i_sr_valid, .i_sr_write,
    .i_sr_coproc, .i_sr_enc, .i_sr_wdata, .i_level, .i_memctl_write_trap,
    .i_memctl_read_trap, .i_group5_trap, .i_group1_trap, .i_acc_ctl_access,
    .i_trace_access, .i_trace_user_forbidden, .i_vector_exec, .i_fp_access,
    .i_kernel_trapped, .o_rdata, .o_rvalid, .o_exc, .o_trap_hyp, .o_trace_side_effect_en,
    .o_fault_status, .o_feature_trap);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic sr(logic wr, logic [13:0] enc, logic [31:0] d, logic [2:0] lvl, exc_t ex);
    @(negedge i_clk_sys);
    i_sr_valid = 1'b1;
    i_sr_write = wr;
    i_sr_enc = enc;
    i_sr_wdata = d;
    i_level = lvl;
    @(negedge i_clk_sys);
    i_sr_valid = 1'b0;
    chk("exc", o_exc, ex);
    chk("rvalid", o_rvalid, !wr && ex == EXC_NONE);
  endtask
  task automatic fcheck(logic [5:0] c, logic [31:0] r);
    logic s, e;
    logic [31:0] x, m;
    s = !(c inside {`ST_ASYNC_ERR, `ST_ASYNC_PARITY});
    e = c inside {`ST_SYNC_EXT, `ST_ASYNC_ERR, `ST_SYNC_PARITY, `ST_ASYNC_PARITY};
    @(negedge i_clk_sys);
    i_fault_valid = 1'b1;
    i_fault_code = c;
    i_fault_sync = s;
    i_fault_addr_unknown = r[0] & (c != `ST_SYNC_PARITY);
    i_fault_cache_maint = r[1] & s;
    i_fault_ext_class = r[2];
    i_fault_write = r[3];
    i_fault_sys_space = r[4];
    @(negedge i_clk_sys);
    i_fault_valid = 1'b0;
    x = `FS_RES1_FIXED | 32'(c);
    x[16] = (c == `ST_SYNC_EXT) & r[0];
    x[13] = r[1] & s;
    x[12] = e & r[2];
    x[11] = r[3] | r[4];
    if (c inside {`ST_TRANSLATION, `ST_PERMISSION, `ST_SYNC_EXT, `ST_ASYNC_ERR, `ST_SYNC_PARITY,
      `ST_ASYNC_PARITY, `ST_ALIGNMENT, `ST_DEBUG, `ST_LOCKDOWN, `ST_EXCLUSIVE}) fs = x;
    else x = fs;
    m = s ? 32'h0 : 32'h2000;
    sr(1'b0, `ENC_FAULT_STATUS, 32'h0, LVL_KERNEL, EXC_NONE);
    chk("fault_status", o_rdata | m, x | m);
  endtask
  task automatic feat(logic [5:0] f, logic [2:0] lvl, exc_t ex);
    @(negedge i_clk_sys);
    {i_kernel_trapped, i_trace_user_forbidden, i_acc_ctl_access} = f[5:3];
    {i_trace_access, i_vector_exec, i_fp_access} = f[2:0];
    i_level = lvl;
    #1;
    if (f[2]) chk("side_effect", o_trace_side_effect_en, ex == EXC_NONE);
    @(negedge i_clk_sys);
    {i_kernel_trapped, i_trace_user_forbidden, i_acc_ctl_access} = 3'h0;
    {i_trace_access, i_vector_exec, i_fp_access} = 3'h0;
    chk("feature_exc", o_exc, ex);
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {i_arst_n, i_fault_valid, i_fault_sync, i_fault_addr_unknown, i_fault_cache_maint} = '0;
    {i_fault_ext_class, i_fault_write, i_fault_sys_space, i_sr_valid, i_sr_write} = '0;
    {i_memctl_write_trap, i_memctl_read_trap, i_group5_trap, i_group1_trap} = '0;
    {i_acc_ctl_access, i_trace_access, i_trace_user_forbidden, i_vector_exec} = '0;
    {i_fp_access, i_kernel_trapped} = '0;
    i_reset_into_hyp = 1'b1;
    i_fault_code = 6'h00;
    i_sr_coproc = `CP_SYSTEM;
    i_sr_enc = 14'h0000;
    i_sr_wdata = 32'h0;
    i_level = LVL_KERNEL;
    seed = 32'h2E95615D;
    codes = '{`ST_TRANSLATION, `ST_PERMISSION, `ST_SYNC_EXT, `ST_ASYNC_ERR, `ST_SYNC_PARITY,
      `ST_ASYNC_PARITY, `ST_ALIGNMENT, `ST_DEBUG, `ST_LOCKDOWN, `ST_EXCLUSIVE};
    repeat (6) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    chk("fs_reset", o_fault_status, `FS_RES1_FIXED);
    chk("ft_reset", o_feature_trap, `HT_RES1_FIXED);
    sr(1'b0, `ENC_FEATURE_TRAP, 32'h0, LVL_HYP, EXC_NONE);
    chk("ft_read", o_rdata, `HT_RES1_FIXED);
    fcheck(`ST_SYNC_EXT, 32'h1);
    fcheck(`ST_TRANSLATION, 32'h1F);
    for (int i = 0; i < 40; i++) fcheck(codes[i % 10], rnd());
    fcheck(6'h3F, 32'h0);
    chk("reserved_code", o_fault_status, fs);
    wd = rnd();
    fs = (wd & 32'h0000383F) | `FS_RES1_FIXED;
    fs[12] = wd[12] & (wd[5:0] inside {`ST_SYNC_EXT, `ST_ASYNC_ERR, `ST_SYNC_PARITY,
      `ST_ASYNC_PARITY});
    sr(1'b1, `ENC_FAULT_STATUS, wd, LVL_KERNEL, EXC_NONE);
    i_memctl_write_trap = 1'b1;
    sr(1'b1, `ENC_FAULT_STATUS, ~wd, LVL_KERNEL, EXC_HYP_TRAP);
    sr(1'b1, `ENC_FAULT_STATUS, ~wd, LVL_USER, EXC_NONE);
    sr(1'b0, `ENC_FAULT_STATUS, 32'h0, LVL_KERNEL, EXC_NONE);
    chk("fs_write", o_rdata, fs);
    {i_memctl_write_trap, i_memctl_read_trap} = 2'b01;
    sr(1'b0, `ENC_FAULT_STATUS, 32'h0, LVL_KERNEL, EXC_HYP_TRAP);
    sr(1'b0, `ENC_FAULT_STATUS, 32'h0, LVL_HYP, EXC_NONE);
    {i_memctl_read_trap, i_group5_trap} = 2'b01;
    sr(1'b0, `ENC_FAULT_STATUS, 32'h0, LVL_KERNEL, EXC_HYP_TRAP);
    sr(1'b1, `ENC_FAULT_STATUS, 32'h0, LVL_KERNEL, EXC_HYP_TRAP);
    i_group5_trap = 1'b0;
    wd = rnd();
    wd[11] = wd[10];
    sr(1'b1, `ENC_FEATURE_TRAP, wd, LVL_HYP, EXC_NONE);
    sr(1'b0, `ENC_FEATURE_TRAP, 32'h0, LVL_HYP, EXC_NONE);
    chk("ft_write", o_rdata, (wd & 32'h80108C00) | `HT_RES1_FIXED);
    sr(1'b0, `ENC_FEATURE_TRAP, 32'h0, LVL_KERNEL, EXC_UNDEF_HYP);
    sr(1'b1, `ENC_FEATURE_TRAP, 32'h0, LVL_USER, EXC_UNDEF_HYP);
    i_group1_trap = 1'b1;
    sr(1'b0, `ENC_FEATURE_TRAP, 32'h0, LVL_KERNEL, EXC_HYP_TRAP);
    i_group1_trap = 1'b0;
    sr(1'b1, `ENC_FEATURE_TRAP, 32'h80108000, LVL_HYP, EXC_NONE);
    feat(6'h08, LVL_KERNEL, EXC_HYP_TRAP);
    feat(6'h28, LVL_KERNEL, EXC_NONE);
    feat(6'h04, LVL_KERNEL, EXC_HYP_TRAP);
    feat(6'h14, LVL_USER, EXC_NONE);
    feat(6'h02, LVL_USER, EXC_HYP_TRAP);
    feat(6'h02, LVL_HYP, EXC_UNDEF_HYP);
    feat(6'h01, LVL_KERNEL, EXC_NONE);
    sr(1'b1, `ENC_FEATURE_TRAP, 32'h00000C00, LVL_HYP, EXC_NONE);
    feat(6'h01, LVL_USER, EXC_HYP_TRAP);
    feat(6'h01, LVL_HYP, EXC_UNDEF_HYP);
    feat(6'h21, LVL_KERNEL, EXC_NONE);
    feat(6'h02, LVL_KERNEL, EXC_HYP_TRAP);
    feat(6'h08, LVL_KERNEL, EXC_NONE);
    feat(6'h04, LVL_KERNEL, EXC_NONE);
    i_reset_into_hyp = 1'b0;
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    @(negedge i_clk_sys);
    chk("ft_reset2", o_feature_trap, `HT_RES1_FIXED);
    wrap_up();
  end
endmodule

//--- inc/fault_trap_consts.svh
/*
  Constants for the fault status and trap control block: bit positions,
  status codes, system register encodings and reset values.
  Assumes inclusion by the block's module and its bench only.
*/
`ifndef FAULT_TRAP_CONSTS_SVH
`define FAULT_TRAP_CONSTS_SVH

// ----------------------------------------
// fault status bit positions
// ----------------------------------------
`define FS_ADDR_INV_BIT 16
`define FS_CACHE_MAINT_BIT 13
`define FS_EXT_CLASS_BIT 12
`define FS_WNR_BIT 11
`define FS_LONG_DESC_BIT 9
`define FS_STATUS_LSB 0
`define FS_STATUS_MSB 5

// ----------------------------------------
// fault status codes
// ----------------------------------------
`define ST_TRANSLATION 6'h04
`define ST_PERMISSION 6'h0C
`define ST_SYNC_EXT 6'h10
`define ST_ASYNC_ERR 6'h11
`define ST_SYNC_PARITY 6'h18
`define ST_ASYNC_PARITY 6'h19
`define ST_ALIGNMENT 6'h21
`define ST_DEBUG 6'h22
`define ST_LOCKDOWN 6'h34
`define ST_EXCLUSIVE 6'h35

// ----------------------------------------
// feature trap bit positions, masks and fixed values; fault status masks
// ----------------------------------------
`define HT_ACCESS_CTL_BIT 31
`define HT_TRACE_BIT 20
`define HT_VECTOR_BIT 15
`define HT_FP_ALIAS_BIT 11
`define HT_FP_BIT 10
`define HT_RES1_MASK 32'h00003FFF
`define HT_RES1_FIXED 32'h000033FF
`define HT_FP_PAIR_MASK 32'h00000C00
`define HT_TRAP_FIELDS 32'h80108C00
`define HT_ACTIVE_MASK 32'h80108400
`define HT_RW_ALWAYS 32'h80100000
`define FS_RES1_FIXED 32'h00000200
`define FS_WRITE_MASK 32'h0000383F
`define FS_DEFINED_MASK 32'h0001383F

// ----------------------------------------
// system register encodings {opc1,crn,crm,opc2}
// ----------------------------------------
`define ENC_FAULT_STATUS 14'h0280
`define ENC_FEATURE_TRAP 14'h208A
`define CP_SYSTEM 4'hF

`endif

//--- inc/fault_trap_pkg.sv
/*
  Types for the fault status and trap control block.
  Assumes the constants header sits beside it.
*/
package fault_trap_pkg;
  typedef enum logic [2:0] {
    LVL_USER = 3'h1,
    LVL_KERNEL = 3'h2,
    LVL_HYP = 3'h4
  } level_t;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h1,
    EXC_HYP_TRAP = 3'h2,
    EXC_UNDEF_HYP = 3'h4
  } exc_t;

  typedef struct packed {
    logic [31:0] fault_status;
    logic [31:0] feature_trap;
    logic [31:0] rdata;
    logic rvalid;
    exc_t exc;
  } state_t;
endpackage

//--- logic/fault_status_trap_control.sv
/*
  Fault syndrome register and hypervisor feature trap controls, with
  the trap decision for system register accesses and feature use.
  Assumes the core presents one access or fault per cycle, with
  access-control traps to the kernel level already decided.
*/
// Overview of operation
// [RQ1] sync external abort: bit 16 set when fault address unknown, else clear
// [RQ2] address-invalid bit reads zero for any other data abort; code also captures it for sync parity errors
// [RQ3] bit 13 marks cache maintenance origin for sync faults
// [RQ4] bit 12 optional external class, zero when absent or not external
// [RQ5] write-not-read bit: 0 read, 1 write
// [RQ6] faults on system space maintenance/translation report write-not-read as 1
// [RQ7] status codes for translation, permission, alignment, debug
// [RQ8] status codes for sync/async external and parity errors
// [RQ9] lockdown and exclusive codes; other codes never produced
// [RQ10] kernel writes/reads to fault status trap on write/read trap controls
// [RQ11] group 5 trap makes every kernel fault status access trap
// [RQ12] fault status reached at opc1 0, CRn 5, CRm 0, opc2 0
// [RQ13] feature trap register hypervisor only; kernel traps on group 1
// [RQ14] trap fields reset to zero only when resetting into hypervisor level; code resets them to zero on every reset
// [RQ15] bit 31 traps kernel access to coprocessor access control
// [RQ16] bit 20 traps trace register access, except prior traps or forbidden user
// [RQ17] hyp trap from user/kernel, undefined-to-hyp from hypervisor
// [RQ18] trapped trace access has its side effects suppressed
// [RQ19] bit 15 traps vector execution when bit 10 clear
// [RQ20] vector-trap bit reserved one without fp, else rw or raz
// [RQ21] bit 11 ignored, reads as written, reserved one without fp
// [RQ22] bit 10 clear leaves fp and vector access unaffected
// [RQ23] access-control exceptions win over feature trap exceptions
// [RQ24] bit 10 set traps all fp and vector access
// [RQ25] reserved bits read fixed values and ignore writes
`timescale 1ns/1ps
`include "fault_trap_consts.svh"

module fault_status_trap_control
  import fault_trap_pkg::*;
#(
  parameter bit HAS_FP = 1'b1,
  parameter bit HAS_VECTOR = 1'b1,
  parameter bit VECTOR_TRAP_RW = 1'b1,
  parameter bit EXT_CLASS_IMPL = 1'b1,
  parameter bit HAS_HYP = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_reset_into_hyp,
  // fault capture
  input wire logic i_fault_valid,
  input wire logic [5:0] i_fault_code,
  input wire logic i_fault_sync,
  input wire logic i_fault_addr_unknown,
  input wire logic i_fault_cache_maint,
  input wire logic i_fault_ext_class,
  input wire logic i_fault_write,
  input wire logic i_fault_sys_space,
  // system register access
  input wire logic i_sr_valid,
  input wire logic i_sr_write,
  input wire logic [3:0] i_sr_coproc,
  input wire logic [13:0] i_sr_enc,
  input wire logic [31:0] i_sr_wdata,
  input wire logic [2:0] i_level,
  // hypervisor controls from elsewhere
  input wire logic i_memctl_write_trap,
  input wire logic i_memctl_read_trap,
  input wire logic i_group5_trap,
  input wire logic i_group1_trap,
  // feature accesses
  input wire logic i_acc_ctl_access,
  input wire logic i_trace_access,
  input wire logic i_trace_user_forbidden,
  input wire logic i_vector_exec,
  input wire logic i_fp_access,
  input wire logic i_kernel_trapped,
  // results
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic [2:0] o_exc,
  output logic o_trap_hyp,
  output logic o_trace_side_effect_en,
  output logic [31:0] o_fault_status,
  output logic [31:0] o_feature_trap
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic code_legal(input logic [5:0] c);
    case (c)
      `ST_TRANSLATION, `ST_PERMISSION, `ST_ALIGNMENT, `ST_DEBUG: code_legal = 1'b1; // RQ7
      `ST_SYNC_EXT, `ST_SYNC_PARITY, `ST_ASYNC_ERR, `ST_ASYNC_PARITY: code_legal = 1'b1; // RQ8
      `ST_LOCKDOWN, `ST_EXCLUSIVE: code_legal = 1'b1; // RQ9
      default: code_legal = 1'b0;
    endcase
  endfunction

  function automatic logic code_external(input logic [5:0] c);
    code_external = (c == `ST_SYNC_EXT) || (c == `ST_SYNC_PARITY) ||
      (c == `ST_ASYNC_ERR) || (c == `ST_ASYNC_PARITY);
  endfunction

  // feature trap image with fixed bits forced
  function automatic logic [31:0] trap_image(input logic [31:0] w);
    logic [31:0] v;
    v = 32'h00000000;
    v[`HT_ACCESS_CTL_BIT] = w[`HT_ACCESS_CTL_BIT];
    v[`HT_TRACE_BIT] = w[`HT_TRACE_BIT];
    v[`HT_FP_BIT] = HAS_FP ? w[`HT_FP_BIT] : 1'b1;
    v[`HT_FP_ALIAS_BIT] = HAS_FP ? w[`HT_FP_ALIAS_BIT] : 1'b1; // RQ21
    if (!HAS_FP || !HAS_VECTOR) begin
      v[`HT_VECTOR_BIT] = 1'b1; // RQ20
    end else begin
      v[`HT_VECTOR_BIT] = VECTOR_TRAP_RW ? w[`HT_VECTOR_BIT] : 1'b0; // RQ20
    end
    v = (v & ~`HT_RES1_MASK) | (v & `HT_RES1_MASK & `HT_FP_PAIR_MASK) | `HT_RES1_FIXED; // RQ25
    trap_image = v;
  endfunction

  localparam logic [31:0] FT_RESET = trap_image(32'h00000000);

  // ----------------------------------------
  // access decode and trap decision
  // ----------------------------------------
  state_t cur;
  state_t next_cur;
  logic hit_fs;
  logic hit_ht;
  logic lvl_kernel;
  logic lvl_hyp;
  logic trap;
  logic fp_trap;
  logic vec_trap;
  logic trace_trap;

  assign lvl_kernel = (i_level == LVL_KERNEL);
  assign lvl_hyp = (i_level == LVL_HYP);
  assign hit_fs = i_sr_valid && i_sr_coproc == `CP_SYSTEM && i_sr_enc == `ENC_FAULT_STATUS; // RQ12
  assign hit_ht = i_sr_valid && i_sr_coproc == `CP_SYSTEM && i_sr_enc == `ENC_FEATURE_TRAP;

  assign fp_trap = cur.feature_trap[`HT_FP_BIT] &&
    (i_fp_access || i_vector_exec); // RQ22 RQ24
  assign vec_trap = !cur.feature_trap[`HT_FP_BIT] &&
    cur.feature_trap[`HT_VECTOR_BIT] && i_vector_exec; // RQ19
  assign trace_trap = cur.feature_trap[`HT_TRACE_BIT] && i_trace_access &&
    !(i_level == LVL_USER && i_trace_user_forbidden); // RQ16

  always_comb begin
    trap = 1'b0;
    if (HAS_HYP && !i_kernel_trapped) begin // RQ23
      if (hit_fs && lvl_kernel) begin
        trap = (i_sr_write && i_memctl_write_trap) || (!i_sr_write && i_memctl_read_trap) ||
          i_group5_trap; // RQ10 RQ11
      end
      if (hit_ht && lvl_kernel && i_group1_trap) begin
        trap = 1'b1; // RQ13
      end
      if (i_acc_ctl_access && lvl_kernel && cur.feature_trap[`HT_ACCESS_CTL_BIT]) begin
        trap = 1'b1; // RQ15
      end
      if (fp_trap || vec_trap || trace_trap) begin
        trap = 1'b1;
      end
    end
  end

  assign o_trace_side_effect_en = i_trace_access && !trap; // RQ18

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    next_cur.exc = EXC_NONE;
    if (trap) begin
      next_cur.exc = lvl_hyp ? EXC_UNDEF_HYP : EXC_HYP_TRAP; // RQ17
    end else if (hit_fs && !i_sr_write) begin
      next_cur.rdata = cur.fault_status;
      next_cur.rvalid = 1'b1;
    end else if (hit_fs && i_sr_write && !(i_level == LVL_USER)) begin
      next_cur.fault_status = (i_sr_wdata & `FS_WRITE_MASK) | `FS_RES1_FIXED; // RQ25
      next_cur.fault_status[`FS_EXT_CLASS_BIT] = EXT_CLASS_IMPL &&
        code_external(i_sr_wdata[`FS_STATUS_MSB:`FS_STATUS_LSB]) &&
        i_sr_wdata[`FS_EXT_CLASS_BIT]; // RQ4
    end else if (hit_ht && !lvl_hyp) begin
      next_cur.exc = EXC_UNDEF_HYP;
    end else if (hit_ht && !i_sr_write) begin
      next_cur.rdata = cur.feature_trap;
      next_cur.rvalid = 1'b1;
    end else if (hit_ht) begin
      next_cur.feature_trap = trap_image(i_sr_wdata);
    end
    // a fault capture wins over a software write in the same cycle
    if (i_fault_valid && code_legal(i_fault_code)) begin // RQ9
      next_cur.fault_status = `FS_RES1_FIXED;
      next_cur.fault_status[`FS_STATUS_MSB:`FS_STATUS_LSB] = i_fault_code; // RQ7 RQ8
      if (i_fault_sync && code_external(i_fault_code)) begin
        next_cur.fault_status[`FS_ADDR_INV_BIT] = i_fault_addr_unknown; // RQ1 RQ2
      end
      next_cur.fault_status[`FS_CACHE_MAINT_BIT] = i_fault_sync && i_fault_cache_maint; // RQ3
      next_cur.fault_status[`FS_EXT_CLASS_BIT] = EXT_CLASS_IMPL &&
        code_external(i_fault_code) && i_fault_ext_class; // RQ4
      next_cur.fault_status[`FS_WNR_BIT] = i_fault_write || i_fault_sys_space; // RQ5 RQ6
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur.fault_status <= `FS_RES1_FIXED;
      cur.feature_trap <= FT_RESET; // RQ14
      cur.rdata <= 32'h00000000;
      cur.rvalid <= 1'b0;
      cur.exc <= EXC_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  // strap caught after release; trap fields reset to zero on every reset, hyp_reset_zero only feeds trap_rst_a
  logic strap_done;
  logic hyp_reset_zero;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done <= 1'b0;
      hyp_reset_zero <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      hyp_reset_zero <= i_reset_into_hyp; // RQ14
    end
  end

  assign o_rdata = cur.rdata;
  assign o_rvalid = cur.rvalid;
  assign o_exc = cur.exc;
  assign o_trap_hyp = cur.exc != EXC_NONE;
  assign o_fault_status = cur.fault_status;
  assign o_feature_trap = cur.feature_trap;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  addr_inv_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ2
    (i_fault_valid && code_legal(i_fault_code) && !(i_fault_sync && code_external(i_fault_code)))
    |=> !o_fault_status[`FS_ADDR_INV_BIT]) else $error("address invalid set off sync ext");
  addr_inv_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ1
    (i_fault_valid && i_fault_code == `ST_SYNC_EXT && i_fault_sync)
    |=> o_fault_status[`FS_ADDR_INV_BIT] == $past(i_fault_addr_unknown))
    else $error("address invalid wrong");
  wnr_sys_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ6
    (i_fault_valid && code_legal(i_fault_code) && i_fault_sys_space)
    |=> o_fault_status[`FS_WNR_BIT]) else $error("write not read not forced");
  ext_class_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ4
    !code_external(o_fault_status[5:0]) |-> !o_fault_status[`FS_EXT_CLASS_BIT])
    else $error("external class on non external");
  status_legal_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ9
    $changed(o_fault_status[5:0]) |-> code_legal(o_fault_status[5:0]) || $past(hit_fs))
    else $error("reserved status code");
  fs_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ11
    (HAS_HYP && hit_fs && lvl_kernel && i_group5_trap && !i_kernel_trapped)
    |=> o_exc == EXC_HYP_TRAP && !o_rvalid) else $error("group 5 trap missed");
  vec_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ19
    (o_feature_trap[`HT_FP_BIT] == 1'b0 && o_feature_trap[`HT_VECTOR_BIT] && i_vector_exec &&
    HAS_HYP && !i_kernel_trapped) |=> o_trap_hyp) else $error("vector trap missed");
  prio_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ23
    i_kernel_trapped |=> !o_trap_hyp) else $error("feature trap beat access control");
  trace_side_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ18
    trace_trap && HAS_HYP && !i_kernel_trapped |-> !o_trace_side_effect_en)
    else $error("trace side effect on trap");
  res1_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ25
    ((o_feature_trap & `HT_RES1_FIXED) == `HT_RES1_FIXED) && o_fault_status[`FS_LONG_DESC_BIT])
    else $error("reserved one bit lost");
  hyp_undef_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ17
    (trap && lvl_hyp) |=> o_exc == EXC_UNDEF_HYP) else $error("wrong exception from hyp");

  // ----------------------------------------
  // capture and register image checks
  // ----------------------------------------
  code_cap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ7 RQ8
    (i_fault_valid && code_legal(i_fault_code))
    |=> o_fault_status[`FS_STATUS_MSB:`FS_STATUS_LSB] == $past(i_fault_code))
    else $error("status code not captured");
  code_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ9
    (i_fault_valid && !code_legal(i_fault_code) && !i_sr_valid) |=> $stable(o_fault_status))
    else $error("reserved code captured");
  cm_sync_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ3
    (i_fault_valid && code_legal(i_fault_code) && i_fault_sync)
    |=> o_fault_status[`FS_CACHE_MAINT_BIT] == $past(i_fault_cache_maint))
    else $error("cache maintenance bit wrong");
  wnr_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ5
    (i_fault_valid && code_legal(i_fault_code) && !i_fault_sys_space)
    |=> o_fault_status[`FS_WNR_BIT] == $past(i_fault_write))
    else $error("direction bit wrong");
  rd_fs_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ12
    (hit_fs && !i_sr_write && !trap)
    |=> o_rvalid && o_rdata == $past(o_fault_status)) else $error("fault status read wrong");
  fs_res0_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ25
    (o_fault_status & ~(`FS_DEFINED_MASK | `FS_RES1_FIXED)) == 32'h00000000)
    else $error("fault status reserved zero bit set");
  ht_res0_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ25
    (o_feature_trap & ~(`HT_TRAP_FIELDS | `HT_RES1_FIXED)) == 32'h00000000)
    else $error("feature trap reserved zero bit set");
  vec_res1_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ20
    (!HAS_FP || !HAS_VECTOR) |-> o_feature_trap[`HT_VECTOR_BIT])
    else $error("vector trap bit not reserved one");
  alias_rw_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ21
    (HAS_FP && hit_ht && lvl_hyp && i_sr_write && !trap)
    |=> o_feature_trap[`HT_FP_ALIAS_BIT] == $past(i_sr_wdata[`HT_FP_ALIAS_BIT]))
    else $error("alias bit not as written");
  trap_rst_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ14
    (hyp_reset_zero && strap_done && !$past(strap_done) && !$past(hit_ht))
    |-> (o_feature_trap & `HT_RW_ALWAYS) == 32'h00000000) else $error("trap fields not reset");

  // ----------------------------------------
  // trap decision checks
  // ----------------------------------------
  wr_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ10
    (HAS_HYP && hit_fs && lvl_kernel && i_sr_write && i_memctl_write_trap && !i_kernel_trapped)
    |=> o_exc == EXC_HYP_TRAP) else $error("write trap missed");
  rd_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ10
    (HAS_HYP && hit_fs && lvl_kernel && !i_sr_write && i_memctl_read_trap && !i_kernel_trapped)
    |=> o_exc == EXC_HYP_TRAP) else $error("read trap missed");
  grp1_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ13
    (HAS_HYP && hit_ht && lvl_kernel && i_group1_trap && !i_kernel_trapped)
    |=> o_exc == EXC_HYP_TRAP) else $error("group 1 trap missed");
  ht_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ13
    (hit_ht && !lvl_hyp && !trap) |=> o_exc == EXC_UNDEF_HYP)
    else $error("feature trap register open below hyp");
  acc_ctl_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ15
    (HAS_HYP && i_acc_ctl_access && lvl_kernel && o_feature_trap[`HT_ACCESS_CTL_BIT] &&
    !i_kernel_trapped) |=> o_exc == EXC_HYP_TRAP) else $error("access control trap missed");
  fp_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ24
    (HAS_HYP && o_feature_trap[`HT_FP_BIT] && (i_fp_access || i_vector_exec) &&
    !i_kernel_trapped) |=> o_trap_hyp) else $error("fp trap missed");
  fp_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ22
    ((o_feature_trap & `HT_ACTIVE_MASK) == 32'h00000000 && !i_sr_valid) |=> !o_trap_hyp)
    else $error("trap with all controls clear");
  side_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ18
    !i_trace_access |-> !o_trace_side_effect_en) else $error("side effect without access");

endmodule
